// ### nav_code_map.vh
// Purpose : Constants for the navigation signal code generator
// Assumes : 25 MHz reference clock, all timing counted from it
// Notes   : Included by nav_signal_code_generator.v
`ifndef NAV_CODE_MAP_VH
`define NAV_CODE_MAP_VH

// =====================================================================
// Clock and chip rate
`define CLK_RATE_KHZ      15'd25000
`define CHIP_RATE_KHZ     15'd511
`define CHIPS_PER_EPOCH   9'd511
`define EPOCH_LAST_CHIP   9'd510

// =====================================================================
// Ranging code register
`define RC_STAGES         9
`define RC_INIT           9'h1ff
`define RC_OUT_STAGE      7
`define RC_TAP_A          5
`define RC_TAP_B          9

// =====================================================================
// String timing
`define STRING_TIME_MS    2000
`define DATA_TIME_MS      1700
`define DATA_BIT_MS       20
`define MEANDER_BIT_MS    10
`define SLOT_LAST_MS      4'd9
`define SLOT_LAST         8'd199
`define SLOT_MARK_FIRST   8'd170
`define DATA_BITS         85
`define MARK_BITS         30

// =====================================================================
// Time mark register
`define TM_STAGES         5
`define TM_INIT           5'h1f
`define TM_TAP_A          3
`define TM_TAP_B          5

`endif

// ### nav_code_monitor.sv
// Purpose: Port assertions for the code generator
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every generator instance
`timescale 1ns/10ps
module nav_code_monitor (
    input wire CLK,
    input wire RST_N,
    input wire STRING_ALIGN,
    input wire DATA_READY,
    input wire MOD_OUT,
    input wire CODE_OUT,
    input wire NAV_OUT,
    input wire CHIP_TICK,
    input wire EPOCH_START,
    input wire STRING_START,
    input wire UNDERRUN
);
// ==========================================================
// Cycle counters
reg [5:0]  gap_q;
reg [14:0] span_q;
always @(posedge CLK) begin
    gap_q  <= (!RST_N || CHIP_TICK || EPOCH_START) ? 6'h0 : gap_q + 6'h1;
    span_q <= (!RST_N || EPOCH_START) ? 15'h0 : span_q + 15'h1;
end
default clocking @(posedge CLK); endclocking
default disable iff (!RST_N);
// ==========================================================
// Assertions
chip_gap_a: assert property (gap_q <= 6'h32)
    else $error("chip gap too long");
epoch_span_a: assert property (span_q <= 15'h61a9)
    else $error("code period too long");
tick_pulse_a: assert property (CHIP_TICK |=> !CHIP_TICK)
    else $error("chip tick too wide");
string_epoch_a: assert property (STRING_START |-> EPOCH_START)
    else $error("string start off epoch");
mod_xor_a: assert property (MOD_OUT == (CODE_OUT ^ NAV_OUT))
    else $error("output not code xor message");
code_init_a: assert property (EPOCH_START |=> CODE_OUT [*8])
    else $error("period does not open with ones");
align_start_a: assert property ($rose(STRING_ALIGN) |-> ##[1:5] STRING_START)
    else $error("string not restarted");
nav_first_a: assert property ($rose(STRING_ALIGN) ##3 STRING_START
    |=> !NAV_OUT [*8])
    else $error("first data bit not zero");
underrun_a: assert property (UNDERRUN |-> DATA_READY)
    else $error("underrun with data held");
cover property (EPOCH_START);
cover property (STRING_START);
cover property (!DATA_READY);
endmodule // nav_code_monitor

bind nav_signal_code_generator nav_code_monitor u_mon (.CLK(CLK),
    .RST_N(RST_N), .STRING_ALIGN(STRING_ALIGN), .DATA_READY(DATA_READY),
    .MOD_OUT(MOD_OUT), .CODE_OUT(CODE_OUT), .NAV_OUT(NAV_OUT),
    .CHIP_TICK(CHIP_TICK), .EPOCH_START(EPOCH_START),
    .STRING_START(STRING_START), .UNDERRUN(UNDERRUN));

// ### nav_data_source.sv
// Purpose: Processor model offering message bits
// Assumes: A bit is taken on a rising edge with valid and ready
// Notes: Valid drops at random to stall
`timescale 1ns/10ps
module nav_data_source (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ready,
    output reg        valid,
    output reg  [0:0] bit_out,
    output reg  [7:0] taken_cnt
);
reg taken_q;
initial begin
    valid = 1'b0;
    bit_out = 1'b0;
end
// ==========================================================
// Offer a bit and hold it until taken
always @(posedge clk) begin
    taken_q <= valid && ready && rst_n;
    taken_cnt <= !rst_n ? 8'h0 : taken_cnt + {7'h0, valid && ready};
end
always @(negedge clk) begin
    if (!rst_n) begin
        valid <= 1'b0;
    end else if (!valid || taken_q) begin
        valid <= 1'($urandom);
        bit_out <= 1'($urandom);
    end
end
endmodule // nav_data_source

// ### nav_signal_code_generator.v
// Purpose : Modulating train of a navigation signal: ranging code,
//           relative-coded message with meander, and time mark
// Assumes : One 25 MHz reference clock; STRING_ALIGN comes from the
//           onboard time scale on even seconds; DATA_* from the
//           onboard processor on the same clock
// Notes   : Chip timing uses a fractional accumulator, exact on average
`timescale 1ns/10ps
`include "nav_code_map.vh"

module nav_signal_code_generator #(
    parameter WIDTH = 1
) (
    input  wire             CLK,
    input  wire             RST_N,
    input  wire             STRING_ALIGN,
    input  wire [WIDTH-1:0] DATA_BIT,
    input  wire             DATA_VALID,
    output wire             DATA_READY,
    output reg              MOD_OUT,
    output reg              CODE_OUT,
    output reg              NAV_OUT,
    output reg              CHIP_TICK,
    output reg              EPOCH_START,
    output reg              STRING_START,
    output reg              UNDERRUN
);

    // =================================================================
    // Alignment input synchroniser and edge detect
    reg        align_s1_q;
    reg        align_s2_q;
    reg        align_s3_q;
    wire       align_evt;

    always @(posedge CLK) begin
        if (!RST_N) begin
            align_s1_q <= 1'b0;
            align_s2_q <= 1'b0;
            align_s3_q <= 1'b0;
        end else begin
            align_s1_q <= STRING_ALIGN;
            align_s2_q <= align_s1_q;
            align_s3_q <= align_s2_q;
        end
    end

    assign align_evt = align_s2_q & ~align_s3_q;

    // =================================================================
    // Two-entry input buffer
    reg  [WIDTH-1:0] buf_mem [0:1];
    reg              wr_ptr_q;
    reg              rd_ptr_q;
    reg  [1:0]       cnt_q;
    wire             buf_empty;
    wire             push;
    wire             pop;
    wire             pop_req;

    assign buf_empty  = (cnt_q == 2'd0);
    assign DATA_READY = (cnt_q != 2'd2);
    assign push       = DATA_VALID & DATA_READY;
    assign pop        = pop_req & ~buf_empty;

    always @(posedge CLK) begin
        if (push) begin
            buf_mem[wr_ptr_q] <= DATA_BIT;
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q    <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 2'd1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 2'd1;
            end
        end
    end

    // =================================================================
    // Chip timing from the reference clock
    reg  [14:0] acc_q;
    reg  [14:0] acc_d;
    reg  [15:0] acc_sum;
    reg         tick_d;

    always @* begin
        acc_sum = {1'b0, acc_q} + {1'b0, `CHIP_RATE_KHZ};
        tick_d  = (acc_sum >= {1'b0, `CLK_RATE_KHZ});
        if (tick_d) begin
            acc_d = acc_sum[14:0] - `CLK_RATE_KHZ;
        end else begin
            acc_d = acc_sum[14:0];
        end
    end

    // =================================================================
    // Epoch, millisecond slot and string counters
    reg  [8:0] chip_q;
    reg  [3:0] sub_ms_q;
    reg  [7:0] slot_q;
    wire       epoch_end;
    wire       slot_end;
    wire [7:0] slot_next;
    wire       in_data;

    assign epoch_end = tick_d & (chip_q == `EPOCH_LAST_CHIP);
    assign slot_end  = epoch_end & (sub_ms_q == `SLOT_LAST_MS);
    assign slot_next = (slot_q == `SLOT_LAST) ? 8'd0 : slot_q + 8'd1;
    assign in_data   = (slot_q < `SLOT_MARK_FIRST);

    always @(posedge CLK) begin
        if (!RST_N || align_evt) begin
            acc_q    <= 15'd0;
            chip_q   <= 9'd0;
            sub_ms_q <= 4'd0;
            slot_q   <= 8'd0;
        end else begin
            acc_q <= acc_d;
            if (tick_d) begin
                chip_q <= epoch_end ? 9'd0 : chip_q + 9'd1;
            end
            if (epoch_end) begin
                sub_ms_q <= slot_end ? 4'd0 : sub_ms_q + 4'd1;
            end
            if (slot_end) begin
                slot_q <= slot_next;
            end
        end
    end

    // =================================================================
    // Ranging code register, one generate stage per bit
    localparam [`RC_STAGES:1] RC_SEED = `RC_INIT;

    reg  [`RC_STAGES:1] rc_q;
    wire [`RC_STAGES:1] rc_d;
    wire                rc_load;
    wire                rc_fb;
    genvar              gi;

    assign rc_load = align_evt | epoch_end;
    assign rc_fb   = rc_q[`RC_TAP_A] ^ rc_q[`RC_TAP_B];

    generate
        for (gi = 1; gi <= `RC_STAGES; gi = gi + 1) begin : g_rc
            if (gi == 1) begin : g_first
                assign rc_d[gi] = rc_load ? RC_SEED[gi]
                                : (tick_d ? rc_fb : rc_q[gi]);
            end else begin : g_next
                assign rc_d[gi] = rc_load ? RC_SEED[gi]
                                : (tick_d ? rc_q[gi-1] : rc_q[gi]);
            end
        end
    endgenerate

    always @(posedge CLK) begin
        if (!RST_N) begin
            rc_q <= `RC_INIT;
        end else begin
            rc_q <= rc_d;
        end
    end

    // =================================================================
    // Message data in relative code
    wire       load_bit;
    reg        rel_q;
    reg        data_now;

    assign load_bit = slot_end & ~slot_next[0]
                      & (slot_next < `SLOT_MARK_FIRST);
    assign pop_req  = load_bit & (slot_next != 8'd0);

    always @* begin
        if (slot_next == 8'd0) begin
            data_now = 1'b0;
        end else if (buf_empty) begin
            data_now = 1'b0;
        end else begin
            data_now = buf_mem[rd_ptr_q][0];
        end
    end

    always @(posedge CLK) begin
        if (!RST_N || align_evt) begin
            rel_q    <= 1'b0;
            UNDERRUN <= 1'b0;
        end else begin
            UNDERRUN <= pop_req & buf_empty;
            if (load_bit) begin
                rel_q <= data_now ^ rel_q;
            end
        end
    end

    // =================================================================
    // Time mark register, one generate stage per bit
    localparam [`TM_STAGES:1] TM_SEED = `TM_INIT;

    reg  [`TM_STAGES:1] tm_q;
    wire [`TM_STAGES:1] tm_d;
    wire                tm_load;
    wire                tm_step;
    wire                tm_fb;

    assign tm_load = align_evt
                     | (slot_end & (slot_next == `SLOT_MARK_FIRST));
    assign tm_step = slot_end & ~in_data & ~tm_load;
    assign tm_fb   = tm_q[`TM_TAP_A] ^ tm_q[`TM_TAP_B];

    generate
        for (gi = 1; gi <= `TM_STAGES; gi = gi + 1) begin : g_tm
            if (gi == 1) begin : g_first
                assign tm_d[gi] = tm_load ? TM_SEED[gi]
                                : (tm_step ? tm_fb : tm_q[gi]);
            end else begin : g_next
                assign tm_d[gi] = tm_load ? TM_SEED[gi]
                                : (tm_step ? tm_q[gi-1] : tm_q[gi]);
            end
        end
    endgenerate

    always @(posedge CLK) begin
        if (!RST_N) begin
            tm_q <= `TM_INIT;
        end else begin
            tm_q <= tm_d;
        end
    end

    // =================================================================
    // Output combiner
    wire code_bit;
    wire nav_bit;

    assign code_bit = rc_q[`RC_OUT_STAGE];
    assign nav_bit  = in_data ? (rel_q ^ slot_q[0])
                              : tm_q[`TM_STAGES];

    // =================================================================
    // Output next values
    reg mod_d;
    reg code_d;
    reg nav_d;
    reg epoch_d;
    reg string_d;

    always @* begin
        code_d   = code_bit;
        nav_d    = nav_bit;
        mod_d    = code_bit ^ nav_bit;
        epoch_d  = epoch_end | align_evt;
        string_d = (slot_end & (slot_next == 8'd0)) | align_evt;
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            MOD_OUT      <= 1'b0;
            CODE_OUT     <= 1'b0;
            NAV_OUT      <= 1'b0;
            CHIP_TICK    <= 1'b0;
            EPOCH_START  <= 1'b0;
            STRING_START <= 1'b0;
        end else begin
            MOD_OUT      <= mod_d;
            CODE_OUT     <= code_d;
            NAV_OUT      <= nav_d;
            CHIP_TICK    <= tick_d;
            EPOCH_START  <= epoch_d;
            STRING_START <= string_d;
        end
    end

endmodule // nav_signal_code_generator

// ### tb.sv
// Purpose: Self-checking bench for the code generator
// Assumes: 25 MHz clock, bits from the source model
// Notes: One full code period is walked after each restart
`timescale 1ns/10ps
module tb;
reg        CLK;
reg        RST_N;
reg        STRING_ALIGN;
wire       DATA_VALID;
wire [0:0] DATA_BIT;
wire       DATA_READY, MOD_OUT, CODE_OUT, NAV_OUT, UNDERRUN;
wire       CHIP_TICK, EPOCH_START, STRING_START;
wire [7:0] taken_cnt;
integer    num_errors = 0;
integer    cmp_count = 0;
integer    cyc, ticks, mid, n, k;
reg [8:0]  lfsr_q;
reg [8:0]  head_q;

always #20 CLK = ~CLK;

nav_signal_code_generator DUT (.CLK(CLK), .RST_N(RST_N),
    .STRING_ALIGN(STRING_ALIGN), .DATA_BIT(DATA_BIT),
    .DATA_VALID(DATA_VALID), .DATA_READY(DATA_READY),
    .MOD_OUT(MOD_OUT), .CODE_OUT(CODE_OUT), .NAV_OUT(NAV_OUT),
    .CHIP_TICK(CHIP_TICK), .EPOCH_START(EPOCH_START),
    .STRING_START(STRING_START), .UNDERRUN(UNDERRUN));
nav_data_source src (.clk(CLK), .rst_n(RST_N), .ready(DATA_READY),
    .valid(DATA_VALID), .bit_out(DATA_BIT), .taken_cnt(taken_cnt));

// ==========================================================
// Helpers
function [8:0] lfsr_next(input [8:0] r);
    lfsr_next = {r[7:0], r[4] ^ r[8]};
endfunction
task check(input logic [31:0] seen, input logic [31:0] exp,
           input string what);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
endtask
task report_and_stop;
    $display("Checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
// Follow one code period chip by chip, sampling mid-chip
task walk;
    lfsr_q = 9'h1ff;
    cyc = 0;
    ticks = 0;
    mid = 24;
    n = 0;
    do begin
        @(negedge CLK);
        cyc = cyc + 1;
        if (CHIP_TICK === 1'b1) begin
            ticks = ticks + 1;
            mid = 24;
        end else begin
            mid = mid - 1;
        end
        if (mid == 0) begin
            check(CODE_OUT, lfsr_q[6], "code");
            check(NAV_OUT, 0, "nav");
            check(MOD_OUT, lfsr_q[6], "mod");
            if (n < 9) head_q = {head_q[7:0], CODE_OUT};
            n = n + 1;
            lfsr_q = lfsr_next(lfsr_q);
        end
    end while (EPOCH_START !== 1'b1 && cyc < 26000);
    check(cyc, 25000, "period");
    check(ticks, 511, "ticks");
    check(head_q, 9'h1fc, "head");
endtask

// ==========================================================
// Main sequence: two restarts, each 100 to 999 cycles into a code period
initial begin
    CLK = 1'b0;
    RST_N = 1'b0;
    STRING_ALIGN = 1'b0;
    k = $urandom(32'hf0cc2be7);
    repeat (6) @(negedge CLK);
    RST_N = 1'b1;
    for (k = 0; k < 2; k = k + 1) begin
        repeat (100 + $urandom % 900) @(negedge CLK);
        STRING_ALIGN = 1'b1;
        cyc = 0;
        while (STRING_START !== 1'b1 && cyc < 10) begin
            @(negedge CLK);
            cyc = cyc + 1;
        end
        check(cyc < 10, 1, "restart");
        check(EPOCH_START, 1, "epoch");
        walk;
        STRING_ALIGN = 1'b0;
        check(DATA_READY, 0, "full");
        check(taken_cnt, 2, "taken");
    end
    report_and_stop;
end
initial begin
    #(40 * 80000);
    num_errors = num_errors + 1;
    report_and_stop;
end
endmodule // tb
